// ### src/ldi_i2c_front.v
// i2c slave front end with call address decode and register pointer
`timescale 1ns/1ns
`default_nettype none
`include "ldi_consts.vh"

// Summary of operation
// - address byte lsb one means read, zero means write
// - regular address formed from seven address select pins
// - reserved values on the pins match like any other address
// - group call address resets to E0h, acknowledged only while I_GROUP_EN is high
// - call addresses writable over the bus, reset to defaults
// - sub-group addresses reset to E2h, E4h and E8h
// - sub-group addresses acknowledged only while their enable inputs are high
// - soft reset call acknowledged only with write direction
// - first byte after an acknowledged write address is control byte
// - low five bits pointer, top three bits auto-increment select
// - enable bit set advances pointer after every data byte
// - selector 000 keeps the pointer fixed
// - selector 100 wraps to 00h after 11h
// - selector 101 wraps to 02h after 11h
// - selector 110 wraps to 0Ah after 0Bh
// - selector 111 wraps to 02h after 0Bh
// - auto-increment changes only the five pointer bits
// - control pointer selects the first register accessed
// - pointer values above 11h are not acknowledged
module ldi_i2c_front (
    input  wire       I_CLK,
    input  wire       I_SRST,
    input  wire [6:0] I_ADDR_SEL,
    input  wire       I_SCL,
    input  wire       I_SDA,
    output wire       O_SDA,
    output wire       O_SDA_OE,
    input  wire       I_SUB1_EN,
    input  wire       I_SUB2_EN,
    input  wire       I_SUB3_EN,
    input  wire       I_GROUP_EN,
    output reg  [4:0] O_REG_ADDR,
    output reg  [7:0] O_WR_DATA,
    output reg        O_WR_STB,
    input  wire [7:0] I_RD_DATA,
    output reg        O_RD_STB,
    output reg  [7:0] O_CTRL_PTR,
    output reg        O_SOFT_RESET_STB,
    output reg        O_STOP_STB
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_AACK = 3'd2;
    localparam [2:0] ST_WBYT = 3'd3;
    localparam [2:0] ST_WACK = 3'd4;
    localparam [2:0] ST_RBYT = 3'd5;
    localparam [2:0] ST_RACK = 3'd6;

    // ----------------------------------------------------------------
    // next pointer by auto-increment selector
    // ----------------------------------------------------------------
    function [4:0] next_ptr;
        input [2:0] sel;
        input [4:0] ptr;
        begin
            case (sel)
            `LDI_SEL_ALL: next_ptr = (ptr == `LDI_PTR_LAST) ?
                `LDI_PTR_ZERO : ptr + 5'h01;
            `LDI_SEL_BRIGHT: next_ptr = (ptr == `LDI_PTR_LAST) ?
                `LDI_PTR_BRIGHT_FIRST : ptr + 5'h01;
            // starts above 0Bh fold back, so the pointer never passes 11h
            // wrap global
            `LDI_SEL_GLOBAL: next_ptr = (ptr >= `LDI_PTR_GLOBAL_LAST) ?
                `LDI_PTR_GLOBAL_FIRST : ptr + 5'h01;
            `LDI_SEL_BRGLOB: next_ptr = (ptr >= `LDI_PTR_GLOBAL_LAST) ?
                `LDI_PTR_BRIGHT_FIRST : ptr + 5'h01;
            // fixed pointer; reserved codes also hold
            default: next_ptr = ptr;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [6:0] addr_s1_reg;
    reg [6:0] addr_s2_reg;
    reg       scl_s1_reg;
    reg       scl_s2_reg;
    reg       scl_d_reg;
    reg       sda_s1_reg;
    reg       sda_s2_reg;
    reg       sda_d_reg;

    // reset to the idle bus level, so no false edge follows reset
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            addr_s1_reg <= 7'h00;
            addr_s2_reg <= 7'h00;
            scl_s1_reg  <= 1'b1;
            scl_s2_reg  <= 1'b1;
            scl_d_reg   <= 1'b1;
            sda_s1_reg  <= 1'b1;
            sda_s2_reg  <= 1'b1;
            sda_d_reg   <= 1'b1;
        end else begin
            addr_s1_reg <= I_ADDR_SEL;
            addr_s2_reg <= addr_s1_reg;
            scl_s1_reg  <= I_SCL;
            scl_s2_reg  <= scl_s1_reg;
            scl_d_reg   <= scl_s2_reg;
            sda_s1_reg  <= I_SDA;
            sda_s2_reg  <= sda_s1_reg;
            sda_d_reg   <= sda_s2_reg;
        end
    end

    // edges read the second and third stages only; the first may still settle
    wire scl_rise = scl_s2_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s2_reg & scl_d_reg;
    // start and stop need the clock high on two samples in a row
    wire start_c  = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    wire stop_c   = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

    // ----------------------------------------------------------------
    // call address registers, volatile
    // ----------------------------------------------------------------
    reg [7:0] group_call_address_reg;
    reg [7:0] subgroup_address_one_reg;
    reg [7:0] subgroup_address_two_reg;
    reg [7:0] subgroup_address_three_reg;

    // ----------------------------------------------------------------
    // protocol state
    // ----------------------------------------------------------------
    reg [2:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg       ack_reg;
    reg       sda_drv_reg;
    // first_reg: the next written byte is the control byte
    reg       first_reg;
    reg       is_reset_call_reg;

    // address byte decode on the shifted byte, direction bit masked except for the soft reset call
    wire [7:0] abyte   = shift_reg;
    wire [6:0] a7      = abyte[7:1];
    wire hit_reg_adr   = (a7 == addr_s2_reg);
    wire hit_group     = I_GROUP_EN & (a7 == group_call_address_reg[7:1]);
    wire hit_sub1      = I_SUB1_EN & (a7 == subgroup_address_one_reg[7:1]);
    wire hit_sub2      = I_SUB2_EN & (a7 == subgroup_address_two_reg[7:1]);
    wire hit_sub3      = I_SUB3_EN & (a7 == subgroup_address_three_reg[7:1]);
    wire hit_soft_reset_call     = (abyte == `LDI_SOFT_RESET_ADDR);
    // a refused address drops to idle and waits for the next start
    wire hit_any       = hit_reg_adr | hit_group | hit_sub1 | hit_sub2 |
                         hit_sub3;

    // open drain: the pin is only ever pulled low, never driven high
    assign O_SDA    = 1'b0;
    assign O_SDA_OE = sda_drv_reg;

    // ----------------------------------------------------------------
    // byte engine, acknowledge and pointer
    // ----------------------------------------------------------------
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 3'd0;
            shift_reg   <= 8'h00;
            ack_reg     <= 1'b0;
            sda_drv_reg <= 1'b0;
            first_reg   <= 1'b0;
            is_reset_call_reg <= 1'b0;
            O_REG_ADDR  <= 5'h00;
            O_WR_DATA   <= 8'h00;
            O_WR_STB    <= 1'b0;
            O_RD_STB    <= 1'b0;
            O_CTRL_PTR  <= 8'h00;
            O_SOFT_RESET_STB <= 1'b0;
            O_STOP_STB  <= 1'b0;
            group_call_address_reg     <= `LDI_GROUP_ADDR_RST;
            subgroup_address_one_reg   <= `LDI_SUB1_ADDR_RST;
            subgroup_address_two_reg   <= `LDI_SUB2_ADDR_RST;
            subgroup_address_three_reg <= `LDI_SUB3_ADDR_RST;
        end else begin
            O_WR_STB         <= 1'b0;
            O_RD_STB         <= 1'b0;
            O_SOFT_RESET_STB <= 1'b0;
            O_STOP_STB       <= 1'b0;
            if (start_c) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 3'd0;
                ack_reg     <= 1'b0;
                sda_drv_reg <= 1'b0;
            end else if (stop_c) begin
                state_reg   <= ST_IDLE;
                ack_reg     <= 1'b0;
                sda_drv_reg <= 1'b0;
                O_STOP_STB  <= (state_reg != ST_IDLE);
            end else begin
                case (state_reg)
                ST_IDLE: begin
                    // bus ignored until the next start
                    sda_drv_reg <= 1'b0;
                end
                ST_ADDR, ST_WBYT: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        // eighth rise completes the byte; act on the fall
                        if (bit_cnt_reg == 3'd7) begin
                            ack_reg <= 1'b1;
                        end
                    end
                    if (scl_fall && ack_reg) begin
                        ack_reg <= 1'b0;
                        if (state_reg == ST_ADDR) begin
                            is_reset_call_reg <= hit_soft_reset_call;
                            first_reg <= ~abyte[0];
                            if (hit_any || hit_soft_reset_call) begin
                                sda_drv_reg <= 1'b1;
                                state_reg   <= ST_AACK;
                            end else begin
                                state_reg   <= ST_IDLE;
                            end
                        end else if (first_reg) begin
                            if (abyte[`LDI_PTR_MSB:0] <= `LDI_PTR_LAST) begin
                                O_CTRL_PTR  <= abyte;
                                O_REG_ADDR  <= abyte[`LDI_PTR_MSB:0];
                                sda_drv_reg <= 1'b1;
                                state_reg   <= ST_WACK;
                            end else begin
                                state_reg   <= ST_IDLE;
                            end
                        end else begin
                            O_WR_DATA   <= abyte;
                            O_WR_STB    <= 1'b1;
                            sda_drv_reg <= 1'b1;
                            state_reg   <= ST_WACK;
                            case (O_REG_ADDR)
                            `LDI_REG_SUB1:  subgroup_address_one_reg <= abyte;
                            `LDI_REG_SUB2:  subgroup_address_two_reg <= abyte;
                            `LDI_REG_SUB3:
                                subgroup_address_three_reg <= abyte;
                            `LDI_REG_GROUP: group_call_address_reg <= abyte;
                            default: ;
                            endcase
                        end
                    end
                end
                ST_AACK: begin
                    // ack released on the fall that ends the ninth clock
                    if (scl_fall) begin
                        sda_drv_reg <= 1'b0;
                        bit_cnt_reg <= 3'd0;
                        shift_reg   <= 8'h00;
                        if (is_reset_call_reg) begin
                            O_SOFT_RESET_STB <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else if (abyte[0]) begin
                            shift_reg   <= I_RD_DATA;
                            O_RD_STB    <= 1'b1;
                            sda_drv_reg <= ~I_RD_DATA[7];
                            state_reg   <= ST_RBYT;
                        end else begin
                            state_reg   <= ST_WBYT;
                        end
                    end
                end
                ST_WACK: begin
                    // pointer steps after the write strobe has used it
                    if (scl_fall) begin
                        sda_drv_reg <= 1'b0;
                        bit_cnt_reg <= 3'd0;
                        shift_reg   <= 8'h00;
                        if (first_reg) begin
                            first_reg <= 1'b0;
                        end else if (O_CTRL_PTR[7]) begin
                            O_REG_ADDR <= next_ptr(
                                O_CTRL_PTR[7:`LDI_SEL_LSB], O_REG_ADDR);
                        end
                        state_reg <= ST_WBYT;
                    end
                end
                ST_RBYT: begin
                    // next bit leaves in the low phase, clear of the rise
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        if (bit_cnt_reg == 3'd7) begin
                            sda_drv_reg <= 1'b0;
                            state_reg   <= ST_RACK;
                            if (O_CTRL_PTR[7]) begin
                                O_REG_ADDR <= next_ptr(
                                    O_CTRL_PTR[7:`LDI_SEL_LSB], O_REG_ADDR);
                            end
                        end else begin
                            sda_drv_reg <= ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    // master ack taken on the rise, acted on at the fall
                    if (scl_rise) begin
                        ack_reg <= ~sda_s2_reg;
                    end
                    if (scl_fall) begin
                        bit_cnt_reg <= 3'd0;
                        if (ack_reg) begin
                            shift_reg   <= I_RD_DATA;
                            O_RD_STB    <= 1'b1;
                            sda_drv_reg <= ~I_RD_DATA[7];
                            state_reg   <= ST_RBYT;
                        end else begin
                            state_reg   <= ST_IDLE;
                        end
                        ack_reg <= 1'b0;
                    end
                end
                default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // ldi_i2c_front
`default_nettype wire

// ### pkg/ldi_consts.vh
// constants for the led driver i2c address and pointer front end
`ifndef LDI_CONSTS_VH
`define LDI_CONSTS_VH

// ----------------------------------------------------------------
// default call addresses (8-bit form, write direction)
// ----------------------------------------------------------------
`define LDI_GROUP_ADDR_RST   8'hE0
`define LDI_SUB1_ADDR_RST    8'hE2
`define LDI_SUB2_ADDR_RST    8'hE4
`define LDI_SUB3_ADDR_RST    8'hE8
`define LDI_SOFT_RESET_ADDR  8'h06

// ----------------------------------------------------------------
// control byte fields and pointer limits
// ----------------------------------------------------------------
`define LDI_PTR_MSB          4
`define LDI_SEL_LSB          5
`define LDI_PTR_LAST         5'h11
`define LDI_PTR_BRIGHT_FIRST 5'h02
`define LDI_PTR_GLOBAL_FIRST 5'h0A
`define LDI_PTR_GLOBAL_LAST  5'h0B
`define LDI_PTR_ZERO         5'h00
`define LDI_SEL_FIXED        3'h0
`define LDI_SEL_ALL          3'h4
`define LDI_SEL_BRIGHT       3'h5
`define LDI_SEL_GLOBAL       3'h6
`define LDI_SEL_BRGLOB       3'h7

// ----------------------------------------------------------------
// register numbers of the call address registers
// ----------------------------------------------------------------
`define LDI_REG_SUB1         5'h0E
`define LDI_REG_SUB2         5'h0F
`define LDI_REG_SUB3         5'h10
`define LDI_REG_GROUP        5'h11

`endif

// ### test/ldi_props.sv
// concurrent checks on the i2c front end ports
`timescale 1ns/1ns
`default_nettype none
module ldi_props (
    input wire logic       I_CLK,
    input wire logic       I_SRST,
    input wire logic       I_SCL,
    input wire logic       O_SDA_OE,
    input wire logic [4:0] O_REG_ADDR,
    input wire logic [7:0] O_CTRL_PTR,
    input wire logic       O_WR_STB,
    input wire logic       O_RD_STB,
    input wire logic       O_SOFT_RESET_STB
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // ------------------------------------------------------------
    // pointer step model
    // ------------------------------------------------------------
    function automatic logic [4:0] nxt(logic [2:0] s, logic [4:0] p);
        case (s)
            3'h4: return (p == 5'h11) ? 5'h00 : p + 5'h01;
            3'h5: return (p == 5'h11) ? 5'h02 : p + 5'h01;
            3'h6: return (p >= 5'h0B) ? 5'h0A : p + 5'h01;
            3'h7: return (p >= 5'h0B) ? 5'h02 : p + 5'h01;
            default: return p;
        endcase
    endfunction
    // a step moves the pointer while the control byte stays put
    sequence s_move;
        $changed(O_REG_ADDR) && $stable(O_CTRL_PTR);
    endsequence
    sequence s_ctrl_kept;
        $stable(O_CTRL_PTR) [*4];
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_clears: assert property (
        disable iff (1'b0) I_SRST |=> !O_SDA_OE && O_REG_ADDR == 5'h00
        && O_CTRL_PTR == 8'h00) else $error("reset left state");
    a_ptr_step: assert property (
        s_move |-> O_REG_ADDR == nxt(O_CTRL_PTR[7:5], $past(O_REG_ADDR)))
        else $error("pointer step wrong");
    a_ptr_fixed: assert property (
        $stable(O_CTRL_PTR) && O_CTRL_PTR[7:5] == 3'h0
        |-> $stable(O_REG_ADDR)) else $error("fixed pointer moved");
    a_sel_kept: assert property (
        O_WR_STB |=> s_ctrl_kept) else $error("selector disturbed");
    a_ptr_range: assert property (
        O_CTRL_PTR[4:0] <= 5'h11 && O_REG_ADDR <= 5'h11)
        else $error("pointer out of range");
    a_soft_pulse: assert property (
        O_SOFT_RESET_STB |=> !O_SOFT_RESET_STB [*8])
        else $error("soft reset strobe long");
    a_oe_steady: assert property (
        I_SCL && $past(I_SCL) |-> $stable(O_SDA_OE))
        else $error("data moved while clock high");
    a_rd_once: assert property (
        O_RD_STB |=> !O_RD_STB [*8]) else $error("read strobe long");
endmodule // ldi_props
`default_nettype wire

// ### test/ldi_master.sv
// i2c bus master model driving the front end
`timescale 1ns/1ns
`default_nettype none
module ldi_master (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic oe
);
    // bus idles released; oe high pulls the data line low
    initial begin
        scl = 1'b1;
        oe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ph(input logic s, input logic o);
        scl <= s;
        oe <= o;
        hold(10);
    endtask
    // data is set well after the clock fall, so no false stop
    task automatic bt(input logic b, output logic r);
        oe <= ~b;
        hold(10);
        scl <= 1'b1;
        hold(5);
        r = sda;
        hold(5);
        scl <= 1'b0;
        hold(6);
    endtask
    // start also serves as repeated start from a low clock
    task automatic st();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic sp();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        ack = ~r;
    endtask
    task automatic rb(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(1'b1, r);
            d[i] = r;
        end
        bt(last, r);
    endtask
endmodule // ldi_master
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the i2c front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    // no strap at the group call value
    logic [6:0] pins = 7'h15;
    logic [3:0] en = 4'h8;
    logic       scl, moe, dut_oe, wstb, sstb, sdao, rstb, pstb;
    logic [4:0] ra;
    logic [7:0] wd, ctl, last_wd, soft_n = 8'h00;
    logic [7:0] rd_n = 8'h00;
    logic [7:0] stop_n = 8'h00;
    int         fails = 0;
    int         checks = 0;
    // open drain: a released line floats high on its pull-up
    wire        sda = ~moe & (dut_oe ? sdao : 1'b1);
    wire  [7:0] rdd = {3'h5, ra};
    // rows: pins, address byte, enables {grp,s3,s2,s1}, ack
    logic [31:0] arows [16] = '{32'h15_2A_08_01, 32'h15_2B_08_01,
        32'h15_2C_08_00, 32'h78_F0_08_01, 32'h78_F1_08_01,
        32'h15_E0_08_01, 32'h15_E1_08_01, 32'h15_E0_00_00,
        32'h15_E2_08_00, 32'h15_E5_08_00, 32'h15_E9_08_00,
        32'h15_E3_01_01, 32'h15_E4_02_01, 32'h15_E8_04_01,
        32'h15_06_08_01, 32'h15_07_08_00};
    // reserved selectors never sent
    // rows: control byte, pointer after byte one, after byte two
    logic [23:0] prows [5] = '{24'h91_00_01, 24'hB1_02_03,
        24'hCB_0A_0B, 24'hEB_02_03, 24'h05_05_05};
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (wstb) last_wd <= wd;
        if (sstb) soft_n <= soft_n + 8'h01;
        if (rstb) rd_n <= rd_n + 8'h01;
        if (pstb) stop_n <= stop_n + 8'h01;
    end
    ldi_master M (.clk(clk), .sda(sda), .scl(scl), .oe(moe));
    ldi_i2c_front DUT (.I_CLK(clk), .I_SRST(srst), .I_ADDR_SEL(pins),
        .I_SCL(scl), .I_SDA(sda), .O_SDA(sdao), .O_SDA_OE(dut_oe),
        .I_SUB1_EN(en[0]), .I_SUB2_EN(en[1]), .I_SUB3_EN(en[2]),
        .I_GROUP_EN(en[3]), .O_REG_ADDR(ra), .O_WR_DATA(wd),
        .O_WR_STB(wstb), .I_RD_DATA(rdd), .O_RD_STB(rstb),
        .O_CTRL_PTR(ctl), .O_SOFT_RESET_STB(sstb), .O_STOP_STB(pstb));
    task automatic chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic rst();
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_addr();
        logic k;
        logic [7:0] d;
        foreach (arows[i]) begin
            pins <= arows[i][30:24];
            en <= arows[i][11:8];
            M.st();
            M.wb(arows[i][23:16], k);
            chk("ack", arows[i][7:0], {7'h00, k});
            if (k && arows[i][16]) M.rb(1'b1, d);
            M.sp();
        end
        chk("soft", 8'h01, soft_n);
        $display("address test done");
    endtask
    task automatic t_ptr();
        logic k;
        logic [7:0] s0;
        s0 = stop_n;
        foreach (prows[i]) begin
            M.st();
            M.wb(8'h2A, k);
            M.wb(prows[i][23:16], k);
            chk("ctrl", prows[i][23:16], ctl);
            chk("first", {3'h0, prows[i][20:16]}, {3'h0, ra});
            M.wb(prows[i][15:8], k);
            chk("wdata", prows[i][15:8], last_wd);
            chk("step1", prows[i][15:8], {3'h0, ra});
            M.wb(prows[i][7:0], k);
            chk("step2", prows[i][7:0], {3'h0, ra});
            M.sp();
            chk("sel", prows[i][23:16], ctl);
        end
        chk("stops", s0 + 8'h05, stop_n);
        // reserved pointer refused, control byte left alone
        M.st();
        M.wb(8'h2A, k);
        M.wb(8'h92, k);
        chk("badptr", 8'h00, {7'h00, k});
        M.sp();
        chk("ctrl kept", 8'h05, ctl);
        $display("pointer test done");
    endtask
    task automatic t_read();
        logic k;
        logic [7:0] d;
        logic [7:0] r0;
        r0 = rd_n;
        M.st();
        M.wb(8'h2A, k);
        M.wb(8'hE4, k);
        M.st();
        M.wb(8'h2B, k);
        M.rb(1'b0, d);
        chk("rd0", 8'hA4, d);
        M.rb(1'b1, d);
        chk("rd1", 8'hA5, d);
        M.sp();
        chk("rdptr", 8'h06, {3'h0, ra});
        chk("rdstb", r0 + 8'h02, rd_n);
        $display("read test done");
    endtask
    task automatic t_sub();
        logic k;
        M.st();
        M.wb(8'h2A, k);
        M.wb(8'h0E, k);
        M.wb(8'h50, k);
        M.sp();
        en <= 4'h9;
        M.st();
        M.wb(8'h50, k);
        chk("newsub", 8'h01, {7'h00, k});
        M.sp();
        rst();
        chk("rstctl", 8'h00, ctl);
        M.st();
        M.wb(8'h50, k);
        chk("oldsub", 8'h00, {7'h00, k});
        M.st();
        M.wb(8'hE2, k);
        chk("defsub", 8'h01, {7'h00, k});
        M.sp();
        $display("call address test done");
    endtask
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
    initial begin
        rst();
        chk("ctl0", 8'h00, ctl);
        chk("oe0", 8'h00, {7'h00, dut_oe});
        chk("sda0", 8'h00, {7'h00, sdao});
        t_addr();
        t_ptr();
        t_read();
        t_sub();
        end_sim();
    end
endmodule // tb_top
bind ldi_i2c_front ldi_props u_props (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_SCL(I_SCL), .O_SDA_OE(O_SDA_OE), .O_REG_ADDR(O_REG_ADDR),
    .O_CTRL_PTR(O_CTRL_PTR), .O_WR_STB(O_WR_STB), .O_RD_STB(O_RD_STB),
    .O_SOFT_RESET_STB(O_SOFT_RESET_STB));
`default_nettype wire
